// File: hw/rsit_core.sv
// Receive spread interrupt table: per-CPU mask/request vectors,
// redirection table, hash key, multi-queue command, AHB-Lite slave.
// Assumes receive events arrive on the same clock, already timed.
//
// Summary of operation
// - Mask bit zero blocks setting its request bit; one lets it set.
// - Reading request register clears mask bits whose request bits were set.
// - Writing one to a request bit clears the matching mask bit.
// - Writing one to a mask bit sets it; zero leaves it unchanged.
// - Mask register is 32 bits, one per CPU, resets to zero.
// - Request register holds one pending-packet bit per CPU.
// - Request bits set on a receive completion whose mask bit is one.
// - Request bits are write-one-to-clear and reset to zero.
// - Redirection table has 128 byte entries, packed four per word.
// - Only the five low bits of each entry hold the tag.
// - Entry n serves hash index n; entry 0 at word 0 bits 7:0.
// - Forty-byte hash key packed four bytes per word, reset zero.
// - Interrupt-control bit set: mask governs; clear: any packet interrupts.
// - Queue enable field: 00 disabled, 01 hash distribution, rest reserved.
`timescale 1ns/1ps
`default_nettype none
module rsit_core (
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	input  wire logic        hsel_in,
	input  wire logic [15:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	input  wire logic [31:0] rx_done_in,
	input  wire logic [6:0]  hash_idx_in,
	output logic      [4:0]  rx_tag_out,
	output logic      [1:0]  mq_mode_out,
	output logic             rx_irq_out,
	output logic             irq_out
);
	// ==========================================================
	// State
	logic [31:0]      mask;
	logic [31:0]      req;
	logic [31:0]      mqc;
	logic [7:0]       queue_redirection_table [128];
	logic [31:0]      key [rsit_pkg::KEY_WORDS];
	logic [1:0]       ev_stat;
	logic [1:0]       ev_mask;
	rsit_pkg::rsit_req_s dp;
	logic             wr;
	logic             rd;
	logic [31:0]      next_rdata;
	logic [31:0]      rx_gated;
	logic             rx_any;
	logic [1:0]       ev_set;
	logic [15:0]      off;

	// ==========================================================
	// Bus address phase capture
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			dp <= '0;
		end else if (hready_in) begin
			dp.valid <= hsel_in && htrans_in == rsit_pkg::HTRANS_NSEQ;
			dp.write <= hwrite_in;
			dp.addr  <= haddr_in;
		end
	end
	assign wr  = dp.valid && dp.write;
	assign rd  = dp.valid && !dp.write;
	assign off = dp.addr;

	// Zero-wait OKAY responses
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			hreadyout_out <= 1'b1;
			hresp_out     <= rsit_pkg::HRESP_OKAY;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out     <= rsit_pkg::HRESP_OKAY;
		end
	end

	// Incoming receive completions: gated by the mask, and their ungated OR
	assign rx_gated = rx_done_in & mask;
	assign rx_any   = |rx_done_in;

	// ==========================================================
	// Mask register: W1S, cleared by request read or request W1
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mask <= rsit_pkg::ZERO32;
		end else begin
			mask <= (mask
				& ~((rd && off == rsit_pkg::REQ_ADDR) ? hrdata_out : rsit_pkg::ZERO32)
				& ~((wr && off == rsit_pkg::REQ_ADDR) ? hwdata_in : rsit_pkg::ZERO32))
				| ((wr && off == rsit_pkg::MASK_ADDR) ? hwdata_in : rsit_pkg::ZERO32);
		end
	end

	// Request register: set by gated events, W1C, set wins
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			req <= rsit_pkg::ZERO32;
		end else begin
			req <= (req & ~((wr && off == rsit_pkg::REQ_ADDR) ? hwdata_in : rsit_pkg::ZERO32))
				| rx_gated;
		end
	end

	// Multi-queue command register
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mqc <= rsit_pkg::ZERO32;
		end else if (wr && off == rsit_pkg::MQC_ADDR) begin
			mqc <= hwdata_in & rsit_pkg::MQC_WMASK;
		end
	end

	// ==========================================================
	// Redirection table, one byte entry per hash index
	genvar gi;
	generate
		for (gi = 0; gi < 128; gi++) begin : g_queue_redirection_table
			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					queue_redirection_table[gi] <= 8'h00;
				end else if (wr && off == rsit_pkg::QUEUE_REDIRECTION_TABLE_BASE + 16'(4 * (gi / 4))) begin
					queue_redirection_table[gi] <= hwdata_in[8 * (gi % 4) +: 8];
				end
			end
		end
		for (gi = 0; gi < rsit_pkg::KEY_WORDS; gi++) begin : g_key
			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					key[gi] <= rsit_pkg::ZERO32;
				end else if (wr && off == rsit_pkg::KEY_BASE + 16'(4 * gi)) begin
					key[gi] <= hwdata_in;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Read multiplexer on the address-phase address; unmapped reads return zero
	always_comb begin
		next_rdata = rsit_pkg::ZERO32;
		if (haddr_in == rsit_pkg::MASK_ADDR) next_rdata = mask;
		if (haddr_in == rsit_pkg::REQ_ADDR) next_rdata = req;
		if (haddr_in == rsit_pkg::MQC_ADDR) next_rdata = mqc;
		if (haddr_in == rsit_pkg::ISTAT_ADDR) next_rdata = {30'h0, ev_stat};
		if (haddr_in == rsit_pkg::IMASK_ADDR) next_rdata = {30'h0, ev_mask};
		for (int i = 0; i < rsit_pkg::QUEUE_REDIRECTION_TABLE_WORDS; i++) begin
			if (haddr_in == rsit_pkg::QUEUE_REDIRECTION_TABLE_BASE + 16'(4 * i)) begin
				next_rdata = {queue_redirection_table[4 * i + 3], queue_redirection_table[4 * i + 2], queue_redirection_table[4 * i + 1], queue_redirection_table[4 * i]};
			end
		end
		for (int i = 0; i < rsit_pkg::KEY_WORDS; i++) begin
			if (haddr_in == rsit_pkg::KEY_BASE + 16'(4 * i)) next_rdata = key[i];
		end
	end

	// Read data captured at the address phase so the port comes from a flop.
	// The request word captured here is also what the read clears from the mask.
	// Limitation: a read right behind a write to the same word sees the old value.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			hrdata_out <= rsit_pkg::ZERO32;
		end else if (hready_in && hsel_in && htrans_in == rsit_pkg::HTRANS_NSEQ && !hwrite_in) begin
			hrdata_out <= next_rdata;
		end
	end

	// ==========================================================
	// Tag lookup and mode outputs
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_tag_out  <= 5'h00;
			mq_mode_out <= rsit_pkg::MQ_OFF;
		end else begin
			rx_tag_out  <= (mqc[rsit_pkg::MQC_EN_LSB +: 2] == rsit_pkg::MQ_HASH)
				? queue_redirection_table[hash_idx_in][rsit_pkg::TAG_BITS-1:0] : 5'h00;
			mq_mode_out <= mqc[rsit_pkg::MQC_EN_LSB +: 2];
		end
	end

	// Receive interrupt indication toward the host
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_irq_out <= 1'b0;
		end else if (mqc[rsit_pkg::MQC_IEN_BIT]) begin
			rx_irq_out <= |(req & mask);
		end else begin
			rx_irq_out <= rx_any;
		end
	end

	// ==========================================================
	// Sticky event status, W1C with set winning, and mask
	assign ev_set = {rx_any, |rx_gated};
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ev_stat <= 2'h0;
			ev_mask <= 2'h0;
		end else begin
			ev_stat <= (ev_stat & ~((wr && off == rsit_pkg::ISTAT_ADDR)
				? hwdata_in[1:0] : 2'h0)) | ev_set;
			if (wr && off == rsit_pkg::IMASK_ADDR) ev_mask <= hwdata_in[1:0] & rsit_pkg::EV_BITS;
		end
	end
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) irq_out <= 1'b0;
		else irq_out <= |(ev_stat & ev_mask);
	end

	// ==========================================================
	// Assertions
	AST_MASK_GATE: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(rx_done_in[0] && !mask[0] && !req[0]) |=> !req[0] || $past(wr))
		else $error("request set while masked");
	AST_RD_CLR: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(rd && off == rsit_pkg::REQ_ADDR && hrdata_out[0] && !(wr)) |=> !mask[0])
		else $error("mask not cleared by read");
	AST_W1_REQ_MASK: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(wr && off == rsit_pkg::REQ_ADDR && hwdata_in[0] && !(rx_done_in[0] && mask[0]))
		|=> !mask[0] && !req[0] )
		else $error("request write did not clear");
	AST_W1S: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(wr && off == rsit_pkg::MASK_ADDR && hwdata_in[3]) |=> mask[3])
		else $error("mask set failed");
	AST_REQ_SET: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(rx_done_in[1] && mask[1]) |=> req[1])
		else $error("request not set");
	AST_REQ_HOLD: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(req[2] && !(wr && off == rsit_pkg::REQ_ADDR)) |=> req[2])
		else $error("request lost");
	AST_IRQ: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(mqc[rsit_pkg::MQC_IEN_BIT] && |(req & mask)) |=> rx_irq_out)
		else $error("no rx interrupt");
	AST_NOMASK: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(!mqc[rsit_pkg::MQC_IEN_BIT] && rx_any) |=> rx_irq_out)
		else $error("packet did not interrupt");
	AST_TAG: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(mqc[1:0] != rsit_pkg::MQ_HASH) |=> rx_tag_out == 5'h00)
		else $error("tag outside hash mode");
	COV_REQ_READ: cover property (@(posedge clk_in) rd && off == rsit_pkg::REQ_ADDR && |req);
	COV_IRQ: cover property (@(posedge clk_in) irq_out);
	COV_HASH: cover property (@(posedge clk_in) mq_mode_out == rsit_pkg::MQ_HASH);
	COV_DIRECT: cover property (@(posedge clk_in) !mqc[rsit_pkg::MQC_IEN_BIT] && rx_irq_out);

	// ==========================================================
	// Further register and output checks
	// Read data returns the mask as it stood at the address phase
	AST_RD_DATA: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(hready_in && hsel_in && htrans_in == rsit_pkg::HTRANS_NSEQ && !hwrite_in
		&& haddr_in == rsit_pkg::MASK_ADDR) |=> hrdata_out == $past(mask))
		else $error("mask read data wrong");
	// A written one clears a request bit unless a new event sets it
	AST_REQ_W1C: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(wr && off == rsit_pkg::REQ_ADDR && hwdata_in[2] && !(rx_done_in[2] && mask[2]))
		|=> !req[2])
		else $error("request not cleared");
	// A written zero leaves a request bit alone
	AST_REQ_W0: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(req[3] && wr && off == rsit_pkg::REQ_ADDR && !hwdata_in[3]) |=> req[3])
		else $error("request cleared by zero");
	// A mask write never clears a mask bit
	AST_MASK_W0: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(mask[4] && wr && off == rsit_pkg::MASK_ADDR) |=> mask[4])
		else $error("mask cleared by mask write");
	// Mask bits are set only by a mask write
	AST_MASK_SET_ONLY: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(!mask[5] && !(wr && off == rsit_pkg::MASK_ADDR)) |=> !mask[5])
		else $error("mask set without write");
	// A read of the request word keeps mask bits whose request was clear
	AST_RD_KEEP: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(rd && off == rsit_pkg::REQ_ADDR && !hrdata_out[7] && mask[7]) |=> mask[7])
		else $error("mask cleared without request");
	// Request bits rise only on an allowed completion
	AST_REQ_SET_ONLY: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(!req[6] && !(rx_done_in[6] && mask[6])) |=> !req[6])
		else $error("request set without event");
	// Tag output follows the addressed entry in hash mode
	AST_TAG_HASH: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(mqc[1:0] == rsit_pkg::MQ_HASH)
		|=> rx_tag_out == $past(queue_redirection_table[hash_idx_in][rsit_pkg::TAG_BITS-1:0]))
		else $error("tag lookup wrong");
	// Writes to the first table word land in entry zero
	AST_QUEUE_REDIRECTION_TABLE_WR: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(wr && off == rsit_pkg::QUEUE_REDIRECTION_TABLE_BASE) |=> queue_redirection_table[0] == $past(hwdata_in[7:0]))
		else $error("table entry write lost");
	// Writes to the last key word land in it whole
	AST_KEY_WR: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(wr && off == rsit_pkg::KEY_BASE + 16'(4 * (rsit_pkg::KEY_WORDS - 1)))
		|=> key[rsit_pkg::KEY_WORDS - 1] == $past(hwdata_in))
		else $error("key write lost");
	// Mode output mirrors the queue enable field
	AST_MODE: assert property (@(posedge clk_in) disable iff (!nrst_in)
		1'b1 |=> mq_mode_out == $past(mqc[rsit_pkg::MQC_EN_LSB +: 2]))
		else $error("mode output wrong");
	// With the interrupt-control bit set, no receive interrupt while no allowed request is pending
	AST_IRQ_LOW: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(mqc[rsit_pkg::MQC_IEN_BIT] && !(|(req & mask))) |=> !rx_irq_out)
		else $error("spurious rx interrupt");
endmodule : rsit_core
`default_nettype wire

// File: hw/rsit_pkg.sv
// Package for the receive spread interrupt table block.
// Assumes a single 20 MHz clock domain and an AHB-Lite register bus.
package rsit_pkg;
	// ==========================================================
	// Register map (byte addresses)
	localparam logic [15:0] MASK_ADDR    = 16'h5864;
	localparam logic [15:0] REQ_ADDR     = 16'h5868;
	localparam logic [15:0] MQC_ADDR     = 16'h5818;
	localparam logic [15:0] QUEUE_REDIRECTION_TABLE_BASE    = 16'h5C00;
	localparam logic [15:0] KEY_BASE     = 16'h5C80;
	localparam logic [15:0] ISTAT_ADDR   = 16'h5870;
	localparam logic [15:0] IMASK_ADDR   = 16'h5874;
	localparam int          QUEUE_REDIRECTION_TABLE_WORDS   = 32;
	localparam int          KEY_WORDS    = 10;
	localparam int          TAG_BITS     = 5;
	// ==========================================================
	// Field layout
	localparam int          MQC_EN_LSB   = 0;
	localparam int          MQC_IEN_BIT  = 2;
	localparam logic [1:0]  MQ_OFF       = 2'h0;
	localparam logic [1:0]  MQ_HASH      = 2'h1;
	localparam logic [31:0] MQC_WMASK    = 32'hFFFF_0007;
	localparam logic [31:0] ZERO32       = 32'h0000_0000;
	localparam logic [1:0]  EV_BITS      = 2'h3;
	localparam int          EV_REQ       = 0;
	localparam int          EV_RX        = 1;
	// ==========================================================
	// AHB encodings
	localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
	localparam logic        HRESP_OKAY   = 1'h0;
	// Decoded bus request carried from address to data phase
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
	} rsit_req_s;
endpackage : rsit_pkg

// File: tb/tb_top.sv
// Self-checking bench for the receive spread interrupt table block.
// Assumes rsit_core as a lone AHB-Lite slave on one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ==========================================================
	// Signals and shorthand addresses
	localparam logic [15:0] MASK = rsit_pkg::MASK_ADDR;
	localparam logic [15:0] REQ  = rsit_pkg::REQ_ADDR;
	localparam logic [15:0] MQC  = rsit_pkg::MQC_ADDR;
	localparam logic [15:0] TBL  = rsit_pkg::QUEUE_REDIRECTION_TABLE_BASE;
	localparam logic [15:0] KEY  = rsit_pkg::KEY_BASE;
	logic        clk_in      = 1'h0;
	logic        nrst_in     = 1'h0;
	logic        hsel_in     = 1'h0;
	logic        hwrite_in   = 1'h0;
	logic [15:0] haddr_in    = 16'h0000;
	logic [1:0]  htrans_in   = 2'h0;
	logic [2:0]  hsize_in    = 3'h2;
	logic [31:0] hwdata_in   = 32'h0;
	logic [31:0] rx_done_in  = 32'h0;
	logic [6:0]  hash_idx_in = 7'h00;
	logic [31:0] hrdata_out;
	logic [31:0] rd_q;
	logic [4:0]  rx_tag_out;
	logic [1:0]  mq_mode_out;
	logic        hreadyout_out;
	logic        hresp_out;
	logic        rx_irq_out;
	logic        irq_out;
	wire         hready_in = hreadyout_out; // Lone slave drives bus ready
	int          fail_count  = 0;
	int          check_count = 0;
	rsit_core rsit_core_i (.clk_in, .nrst_in, .hsel_in, .haddr_in, .htrans_in,
		.hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out,
		.hreadyout_out, .hresp_out, .rx_done_in, .hash_idx_in,
		.rx_tag_out, .mq_mode_out, .rx_irq_out, .irq_out);
	// ==========================================================
	// Clock, and read data as seen just before each edge
	always #25 clk_in = ~clk_in;
	always @(posedge clk_in) rd_q <= hrdata_out;
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Next edge with ready high, bounded
	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge clk_in);
		while (hready_in !== 1'b1) begin
			n++;
			if (n > 20) begin
				fail_count++;
				final_report;
			end
			@(posedge clk_in);
		end
		#1;
	endtask : wait_rdy
	// One single word transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [15:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel_in <= 1'h1;
		haddr_in <= a;
		htrans_in <= rsit_pkg::HTRANS_NSEQ;
		hwrite_in <= w;
		wait_rdy;
		hsel_in <= 1'h0;
		htrans_in <= 2'h0;
		hwdata_in <= d;
		wait_rdy;
		chk({31'h0, hresp_out}, {31'h0, rsit_pkg::HRESP_OKAY});
		r = rd_q;
	endtask : bus
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'h1, a, d, r);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'h0, a, 32'h0, r);
		chk(r, e);
	endtask : rd
	// One-cycle receive event, then let it land
	task automatic pulse(input logic [31:0] v);
		rx_done_in <= v;
		@(posedge clk_in);
		#1 rx_done_in <= 32'h0;
		repeat (2) @(posedge clk_in);
		#1;
	endtask : pulse
	// ==========================================================
	// Scenarios
	task automatic t_reset;
		rd(MASK, 32'h0);
		rd(REQ, 32'h0);
		rd(TBL + 16'h007C, 32'h0);
		rd(KEY + 16'h0024, 32'h0);
		chk({30'h0, mq_mode_out}, 32'h0);
	endtask : t_reset
	// Masked event, set-only mask, read and write-one clearing
	task automatic t_gate;
		wr(MQC, 32'h0000_0004);
		pulse(32'h0000_0011);
		rd(REQ, 32'h0);
		wr(MASK, 32'h0000_00F0);
		wr(MASK, 32'h0000_000F);
		rd(MASK, 32'h0000_00FF);
		pulse(32'h0000_0013);
		chk({31'h0, rx_irq_out}, 32'h1);
		rd(REQ, 32'h0000_0013);
		rd(MASK, 32'h0000_00EC);
		wr(REQ, 32'h0000_0021);
		rd(MASK, 32'h0000_00CC);
		rd(REQ, 32'h0000_0012);
		wr(REQ, 32'h0000_0012);
		@(posedge clk_in);
		#1;
		chk({31'h0, rx_irq_out}, 32'h0);
	endtask : t_gate
	// Control bit clear: any packet interrupts despite the mask
	task automatic t_direct;
		logic seen;
		seen = 1'h0;
		wr(MQC, 32'h0);
		rx_done_in <= 32'h0000_0100;
		repeat (3) begin
			@(posedge clk_in);
			#1 rx_done_in <= 32'h0;
			if (rx_irq_out === 1'b1) seen = 1'h1;
		end
		chk({31'h0, seen}, 32'h1);
		rd(REQ, 32'h0);
	endtask : t_direct
	// Table packing, tag lookup, key store, unmapped read
	task automatic t_table;
		wr(TBL, 32'h1F3A_2B05);
		wr(TBL + 16'h007C, 32'hE700_0000);
		wr(KEY + 16'h0024, 32'hA5C3_0001);
		wr(MQC, 32'h0000_0001);
		rd(TBL, 32'h1F3A_2B05);
		rd(TBL + 16'h007C, 32'hE700_0000);
		rd(KEY + 16'h0024, 32'hA5C3_0001);
		rd(16'h5900, 32'h0);
		chk({30'h0, mq_mode_out}, 32'h1);
		hash_idx_in <= 7'h7F;
		repeat (2) @(posedge clk_in);
		#1;
		chk({27'h0, rx_tag_out}, 32'h7);
		hash_idx_in <= 7'h01;
		repeat (2) @(posedge clk_in);
		#1;
		chk({27'h0, rx_tag_out}, 32'hB);
	endtask : t_table
	// Event status, its mask and the level interrupt
	task automatic t_events;
		rd(rsit_pkg::ISTAT_ADDR, 32'h3);
		chk({31'h0, irq_out}, 32'h0);
		wr(rsit_pkg::IMASK_ADDR, 32'h1);
		@(posedge clk_in);
		#1;
		chk({31'h0, irq_out}, 32'h1);
		wr(rsit_pkg::ISTAT_ADDR, 32'h1);
		@(posedge clk_in);
		#1;
		chk({31'h0, irq_out}, 32'h0);
		rd(rsit_pkg::ISTAT_ADDR, 32'h2);
	endtask : t_events
	// ==========================================================
	// Main sequence and verdict
	initial begin
		repeat (20) @(posedge clk_in);
		#1 nrst_in <= 1'h1;
		t_reset;
		t_gate;
		t_direct;
		t_table;
		t_events;
		final_report;
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report
endmodule : tb_top
`default_nettype wire
